// ==== design/nwp_top.sv ====
// nvm write protection core with apb registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module nwp_top #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = nwp_pkg::POWERUP_DELAY_TIMER_CYC,
   parameter int unsigned EE_CYCLES   = nwp_pkg::EE_WR_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             mem_wr,
   output logic             mem_rd,
   output logic             mem_space,
   output logic [12:0]      mem_addr,
   output logic [13:0]      mem_wdata,
   input  wire logic [13:0] mem_rdata,
   input  wire logic        prog_area_protected,
   output logic             cpu_stall,
   input  wire logic        ext_rd_req,
   input  wire logic        ext_wr_req,
   input  wire logic        ext_area_protected,
   input  wire logic        ext_cfg_wr,
   input  wire logic [3:0]  ext_cfg_wdata,
   input  wire logic        ext_bulk_erase,
   output logic             ext_rd_ok,
   output logic             ext_wr_ok
);
   typedef struct packed {
      nwp_pkg::nwp_key_t key;
      logic [7:0]  core_irq;
      logic [7:0]  pflag;
      logic [7:0]  pen;
      logic [7:0]  data_lo;
      logic [7:0]  data_hi;
      logic [7:0]  addr_lo;
      logic [7:0]  addr_hi;
      logic        space;
      logic        fault;
      logic        permit;
      logic        wr;
      logic        rd;
      logic        rd_ph;
      logic [1:0]  status;
      logic [1:0]  irq_en;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        mem_wr;
      logic        mem_rd;
      logic        stall;
   } nwp_top_st_t;
   nwp_top_st_t q, d;

   logic [9:0]  idx;
   logic        hit;
   logic [7:0]  rd_val;
   logic        setup;
   logic        acc_wr;
   logic [7:0]  wb;
   logic [3:0]  cfg_word;
   logic        pwr_busy;
   logic        wr_busy;
   logic        wr_last;
   logic        wr_load;
   logic [19:0] wr_len;
   logic        try_wr;
   logic        prog_ok;
   logic        go;
   logic [1:0]  st_set;
   logic [1:0]  st_clr;
   logic        lvl_off;
   logic        lvl_none;

   assign idx = paddr[11:2];
   assign wb  = pwdata[7:0];

   // powerup_delay_timer starts counting at reset release
   nwp_cnt #(
      .RST_VAL (20'(POWERUP_DELAY_TIMER_CYCLES))
   ) u_powerup_delay_timer (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .load     (1'b0),
      .load_val (20'h00000),
      .busy     (pwr_busy),
      .last     ()
   );

   // write cycle length: data write time or the flash stall
   nwp_cnt #(
      .RST_VAL (20'h00000)
   ) u_wrt (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .load     (wr_load),
      .load_val (wr_len),
      .busy     (wr_busy),
      .last     (wr_last)
   );

   // config word only reachable from the programmer side
   nwp_cfg u_cfg (
      .core_clk           (core_clk),
      .nrst               (nrst),
      .clk_en             (clk_en),
      .ext_rd_req         (ext_rd_req),
      .ext_wr_req         (ext_wr_req),
      .ext_area_protected (ext_area_protected),
      .ext_cfg_wr         (ext_cfg_wr),
      .ext_cfg_wdata      (ext_cfg_wdata),
      .ext_bulk_erase     (ext_bulk_erase),
      .ext_rd_ok          (ext_rd_ok),
      .ext_wr_ok          (ext_wr_ok),
      .cfg_word           (cfg_word)
   ); // see (RULE6)

   // read mux and address decode
   always_comb begin
      hit    = 1'b1;
      rd_val = 8'h00;
      case (idx)
         nwp_pkg::IDX_CORE_IRQ: begin
            rd_val = q.core_irq;
         end
         nwp_pkg::IDX_PFLAG2: begin
            rd_val = q.pflag;
            rd_val[nwp_pkg::FLG_DONE] = q.status[nwp_pkg::ST_DONE];
         end
         nwp_pkg::IDX_PEN2: begin
            rd_val = q.pen;
         end
         nwp_pkg::IDX_DATA_LO: begin
            rd_val = q.data_lo;
         end
         nwp_pkg::IDX_ADDR_LO: begin
            rd_val = q.addr_lo;
         end
         nwp_pkg::IDX_DATA_HI: begin
            rd_val = q.data_hi;
         end
         nwp_pkg::IDX_ADDR_HI: begin
            rd_val = q.addr_hi;
         end
         nwp_pkg::IDX_CTL: begin
            rd_val[nwp_pkg::CTL_SPACE]  = q.space;
            rd_val[nwp_pkg::CTL_FAULT]  = q.fault;
            rd_val[nwp_pkg::CTL_PERMIT] = q.permit;
            rd_val[nwp_pkg::CTL_WR]     = q.wr;
            rd_val[nwp_pkg::CTL_RD]     = q.rd;
         end
         nwp_pkg::IDX_KEY: begin
            rd_val = 8'h00; // see (RULE19)
         end
         nwp_pkg::IDX_IRQ_STAT: begin
            rd_val = {6'h00, q.status};
         end
         nwp_pkg::IDX_IRQ_CLR: begin
            rd_val = 8'h00;
         end
         nwp_pkg::IDX_IRQ_EN: begin
            rd_val = {6'h00, q.irq_en};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // start-write qualification
   always_comb begin
      setup  = psel & ~penable;
      acc_wr = psel & penable & q.pready & pwrite & hit;
      try_wr = acc_wr & (idx == nwp_pkg::IDX_CTL) & wb[nwp_pkg::CTL_WR] & ~q.wr & ~wr_busy;
      lvl_off  = cfg_word[nwp_pkg::CFG_HI] & cfg_word[nwp_pkg::CFG_LO];
      lvl_none = ~cfg_word[nwp_pkg::CFG_HI] & ~cfg_word[nwp_pkg::CFG_LO];
      // permit alone decides when protection is off; see (RULE4) see (RULE11)
      prog_ok = cfg_word[nwp_pkg::CFG_SELF] & (lvl_off | (~lvl_none & ~prog_area_protected));
      // key and earlier permit needed for both spaces; see (RULE5) see (RULE15) see (RULE16)
      go = try_wr & (q.key == nwp_pkg::KEY_ARMED) & q.permit;
      if (wb[nwp_pkg::CTL_SPACE]) begin
         go = go & prog_ok;
      end else begin
         go = go & ~pwr_busy; // see (RULE3)
      end
      wr_load = go;
      if (wb[nwp_pkg::CTL_SPACE]) begin
         wr_len = 20'(nwp_pkg::STALL_CYC);
      end else begin
         wr_len = 20'(EE_CYCLES);
      end
   end

   // next state
   always_comb begin
      d        = q;
      d.mem_wr = 1'b0;
      d.mem_rd = 1'b0;
      st_set   = 2'h0;
      st_clr   = 2'h0;
      // apb answers one cycle after setup
      d.pready  = setup;
      d.pslverr = setup & ~hit;
      if (setup) begin
         d.prdata = {24'h000000, rd_val};
      end
      // read sequence: data lands two cycles after start
      if (q.mem_rd) begin
         d.rd_ph = 1'b1;
      end
      if (q.rd_ph) begin
         d.rd_ph   = 1'b0;
         d.rd      = 1'b0;
         d.data_lo = mem_rdata[7:0];
         d.data_hi = {2'h0, mem_rdata[13:8]};
      end
      // completion; see (RULE17)
      if (wr_last & q.wr) begin
         d.wr    = 1'b0;
         d.stall = 1'b0;
         st_set[nwp_pkg::ST_DONE] = 1'b1;
      end
      if (acc_wr) begin
         // any accepted write but 55h, or AAh after 55h, to the key port breaks the sequence
         d.key = nwp_pkg::KEY_IDLE;
         case (idx)
            nwp_pkg::IDX_CORE_IRQ: begin
               d.core_irq = wb;
            end
            nwp_pkg::IDX_PFLAG2: begin
               d.pflag = wb & nwp_pkg::PERIPH_MASK;
               st_clr[nwp_pkg::ST_DONE] = ~wb[nwp_pkg::FLG_DONE];
            end
            nwp_pkg::IDX_PEN2: begin
               // reserved bits kept clear whatever is written; see (RULE14)
               d.pen = wb & nwp_pkg::PERIPH_MASK;
            end
            nwp_pkg::IDX_DATA_LO: begin
               d.data_lo = wb;
            end
            nwp_pkg::IDX_ADDR_LO: begin
               d.addr_lo = wb;
            end
            nwp_pkg::IDX_DATA_HI: begin
               d.data_hi = wb & nwp_pkg::DATH_MASK;
            end
            nwp_pkg::IDX_ADDR_HI: begin
               d.addr_hi = wb & nwp_pkg::ADRH_MASK;
            end
            nwp_pkg::IDX_CTL: begin
               // space frozen while a cycle runs so the target cannot move
               if (!q.wr && !q.rd) begin
                  d.space = wb[nwp_pkg::CTL_SPACE];
               end
               d.permit = wb[nwp_pkg::CTL_PERMIT];
               d.fault  = q.fault & wb[nwp_pkg::CTL_FAULT];
               // reads never gated by protection; see (RULE9) see (RULE10)
               if (wb[nwp_pkg::CTL_RD] && !q.rd && !q.wr) begin
                  d.rd     = 1'b1;
                  d.mem_rd = 1'b1;
               end
            end
            nwp_pkg::IDX_KEY: begin
               if (wb == nwp_pkg::KEY_FIRST) begin
                  d.key = nwp_pkg::KEY_HALF;
               end else begin
                  case (q.key)
                     nwp_pkg::KEY_HALF: begin
                        if (wb == nwp_pkg::KEY_SECOND) begin
                           d.key = nwp_pkg::KEY_ARMED; // see (RULE15)
                        end
                     end
                     nwp_pkg::KEY_IDLE, nwp_pkg::KEY_ARMED: begin
                        d.key = nwp_pkg::KEY_IDLE;
                     end
                     default: begin
                        d.key = nwp_pkg::KEY_IDLE;
                     end
                  endcase
               end
            end
            nwp_pkg::IDX_IRQ_CLR: begin
               st_clr = wb[1:0];
            end
            nwp_pkg::IDX_IRQ_EN: begin
               d.irq_en = wb[1:0];
            end
            default: begin
               d.key = nwp_pkg::KEY_IDLE;
            end
         endcase
      end
      if (go) begin
         d.wr     = 1'b1;
         d.mem_wr = 1'b1;
         d.stall  = wb[nwp_pkg::CTL_SPACE]; // see (RULE18)
      end else if (try_wr) begin
         // refused attempt leaves start clear and is reported
         d.fault = 1'b1;
         st_set[nwp_pkg::ST_REFUSE] = 1'b1;
      end
      // set beats a clear in the same cycle
      d.status = (q.status & ~st_clr) | st_set;
      d.irq    = |(d.status & d.irq_en);
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         q.key      <= nwp_pkg::KEY_IDLE;
         q.core_irq <= 8'h00;
         q.pflag    <= 8'h00;
         q.pen      <= 8'h00;
         q.data_lo  <= 8'h00;
         q.data_hi  <= 8'h00;
         q.addr_lo  <= 8'h00;
         q.addr_hi  <= 8'h00;
         q.space    <= 1'b0;
         q.fault    <= 1'b0;
         q.permit   <= 1'b0; // see (RULE2)
         q.wr       <= 1'b0;
         q.rd       <= 1'b0;
         q.rd_ph    <= 1'b0;
         q.status   <= 2'h0;
         q.irq_en   <= 2'h0;
         q.prdata   <= 32'h00000000;
         q.pready   <= 1'b0;
         q.pslverr  <= 1'b0;
         q.irq      <= 1'b0;
         q.mem_wr   <= 1'b0;
         q.mem_rd   <= 1'b0;
         q.stall    <= 1'b0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign prdata    = q.prdata;
   assign pready    = q.pready;
   assign pslverr   = q.pslverr;
   assign irq       = q.irq;
   assign mem_wr    = q.mem_wr;
   assign mem_rd    = q.mem_rd;
   assign mem_space = q.space;
   assign mem_addr  = {q.addr_hi[4:0], q.addr_lo};
   assign mem_wdata = {q.data_hi[5:0], q.data_lo};
   assign cpu_stall = q.stall;
endmodule // nwp_top

// ==== design/nwp_pkg.sv ====
// constants and types for the nvm write protection block
// Function
// (RULE1) software should read back each written word; weak bits read zero
// (RULE2) store permit is cleared at power-up, blocking data writes
// (RULE3) data writes are refused while the 72 ms power-up delay runs
// (RULE4) self-write permit at zero refuses every internal flash write
// (RULE5) flash writes need the same unlock key sequence as data writes
// (RULE6) processor code can never alter the configuration word
// (RULE7) data and flash each have their own independent code protection
// (RULE8) either code protection enabled blocks external port reads and writes; partial flash protection here still passes reads of unprotected areas
// (RULE9) processor reads and writes data memory whatever its protection
// (RULE10) processor always reads flash whatever protection or permit says
// (RULE11) flash self-write needs permit at one and an unprotected target
// (RULE12) protect level 00 blocks, partial reads unprotected only, 11 full
// (RULE13) permit and protect bits return to erased only by full erase; here reset also reloads the erased word
// (RULE14) software keeps reserved interrupt register bits at zero
// (RULE15) write starts only after 55h then AAh to key port then start
// (RULE16) start is ignored unless store permit was set by earlier write
// (RULE17) completion clears start and sets the sticky done flag
// (RULE18) flash write stalls the processor two cycles, clocks keep running
// (RULE19) key port reads return zero
package nwp_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CORE_IRQ  = 10'h00B;
   localparam logic [9:0] IDX_PFLAG2    = 10'h00D;
   localparam logic [9:0] IDX_PEN2      = 10'h08D;
   localparam logic [9:0] IDX_DATA_LO   = 10'h10C;
   localparam logic [9:0] IDX_ADDR_LO   = 10'h10D;
   localparam logic [9:0] IDX_DATA_HI   = 10'h10E;
   localparam logic [9:0] IDX_ADDR_HI   = 10'h10F;
   localparam logic [9:0] IDX_CTL       = 10'h18C;
   localparam logic [9:0] IDX_KEY       = 10'h18D;
   localparam logic [9:0] IDX_IRQ_STAT  = 10'h1F0;
   localparam logic [9:0] IDX_IRQ_CLR   = 10'h1F1;
   localparam logic [9:0] IDX_IRQ_EN    = 10'h1F2;
   // nvm_control fields
   localparam int CTL_SPACE  = 7;
   localparam int CTL_FAULT  = 3;
   localparam int CTL_PERMIT = 2;
   localparam int CTL_WR     = 1;
   localparam int CTL_RD     = 0;
   localparam int FLG_DONE   = 4;
   localparam logic [7:0] PERIPH_MASK = 8'h19;
   localparam logic [7:0] DATH_MASK   = 8'h3F;
   localparam logic [7:0] ADRH_MASK   = 8'h1F;
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'hAA;
   // interrupt status layout
   localparam int ST_DONE   = 0;
   localparam int ST_REFUSE = 1;
   // configuration word layout, erased state is all ones
   localparam int CFG_SELF = 0;
   localparam int CFG_LO   = 1;
   localparam int CFG_HI   = 2;
   localparam int CFG_DCP  = 3;
   localparam logic [3:0] CFG_ERASED = 4'hF;
   // timing
   localparam int unsigned CLK_HZ     = 10000000;
   localparam int unsigned POWERUP_DELAY_TIMER_MS    = 72;
   localparam int unsigned EE_WR_MS   = 4;
   localparam int unsigned POWERUP_DELAY_TIMER_CYC   = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
   localparam int unsigned EE_WR_CYC  = EE_WR_MS * (CLK_HZ / 1000);
   localparam int unsigned STALL_CYC  = 2;
   localparam int CNT_W = 20;
   typedef enum logic [2:0] {
      KEY_IDLE  = 3'h1,
      KEY_HALF  = 3'h2,
      KEY_ARMED = 3'h4
   } nwp_key_t;
endpackage

// ==== design/nwp_cnt.sv ====
// loadable down counter used for delays
`timescale 1ns/10ps
module nwp_cnt #(
   parameter logic [19:0] RST_VAL = 20'h00000
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        load,
   input  wire logic [19:0] load_val,
   output logic             busy,
   output logic             last
);
   typedef struct packed {
      logic [19:0] cnt;
   } nwp_cnt_st_t;
   nwp_cnt_st_t q, d;

   always_comb begin
      d = q;
      if (load) begin
         d.cnt = load_val;
      end else if (q.cnt != 20'h00000) begin
         d.cnt = q.cnt - 20'h00001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         q.cnt <= RST_VAL;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign busy = (q.cnt != 20'h00000);
   assign last = (q.cnt == 20'h00001);
endmodule // nwp_cnt

// ==== design/nwp_cfg.sv ====
// configuration word and external programming port gate
`timescale 1ns/10ps
module nwp_cfg (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   input  wire logic       ext_rd_req,
   input  wire logic       ext_wr_req,
   input  wire logic       ext_area_protected,
   input  wire logic       ext_cfg_wr,
   input  wire logic [3:0] ext_cfg_wdata,
   input  wire logic       ext_bulk_erase,
   output logic            ext_rd_ok,
   output logic            ext_wr_ok,
   output logic [3:0]      cfg_word
);
   typedef struct packed {
      logic [3:0] cfg;
      logic       rd_ok;
      logic       wr_ok;
   } nwp_cfg_st_t;
   nwp_cfg_st_t q, d;
   logic lvl_off, lvl_part, dcp_off;

   always_comb begin
      d = q;
      lvl_off  = q.cfg[nwp_pkg::CFG_HI] & q.cfg[nwp_pkg::CFG_LO];
      lvl_part = q.cfg[nwp_pkg::CFG_HI] ^ q.cfg[nwp_pkg::CFG_LO];
      dcp_off  = q.cfg[nwp_pkg::CFG_DCP];
      // data protection blocks the port; flash protection blocks writes and protected-area reads; see (RULE7) see (RULE8)
      d.rd_ok = ext_rd_req & dcp_off & (lvl_off | (lvl_part & ~ext_area_protected)); // see (RULE12)
      d.wr_ok = ext_wr_req & dcp_off & lvl_off; // see (RULE12)
      // programming only clears bits; only erase or reset sets them; see (RULE13)
      if (ext_bulk_erase) begin
         d.cfg = nwp_pkg::CFG_ERASED;
      end else if (ext_cfg_wr) begin
         d.cfg = q.cfg & ext_cfg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         q.cfg   <= nwp_pkg::CFG_ERASED;
         q.rd_ok <= 1'b0;
         q.wr_ok <= 1'b0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign ext_rd_ok = q.rd_ok;
   assign ext_wr_ok = q.wr_ok;
   assign cfg_word  = q.cfg;
endmodule // nwp_cfg

// ==== bench/nwp_assertions.sv ====
// concurrent checks on the nvm write protection core ports
`timescale 1ns/10ps
module nwp_checker #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 20
) (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        mem_wr,
   input wire logic        mem_rd,
   input wire logic        mem_space,
   input wire logic        cpu_stall,
   input wire logic        ext_rd_req,
   input wire logic        ext_wr_req,
   input wire logic        ext_rd_ok,
   input wire logic        ext_wr_ok
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic        wacc, keyw, ctlw, perm_q, go_q, rd_q;
   logic [1:0]  key_q;
   logic [19:0] up_q;
   assign wacc = psel && penable && pready && pwrite;
   assign keyw = wacc && paddr[11:2] == nwp_pkg::IDX_KEY;
   assign ctlw = wacc && paddr[11:2] == nwp_pkg::IDX_CTL;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         {key_q, perm_q, go_q, rd_q, up_q} <= '0;
      end else begin
         if (keyw && pwdata[7:0] == nwp_pkg::KEY_FIRST)
            key_q <= 2'h1;
         else if (keyw && pwdata[7:0] == nwp_pkg::KEY_SECOND && key_q == 2'h1)
            key_q <= 2'h2;
         else if (wacc)
            key_q <= 2'h0;
         if (ctlw)
            perm_q <= pwdata[2];
         go_q <= ctlw && pwdata[1] && key_q == 2'h2 && perm_q;
         rd_q <= ctlw && pwdata[0];
         if (up_q < POWERUP_DELAY_TIMER_CYCLES)
            up_q <= up_q + 20'h1;
      end
   end
   sequence s_stall;
      cpu_stall ##1 cpu_stall ##1 !cpu_stall;
   endsequence
   property p_flash_stall;
      mem_wr && mem_space |-> s_stall;
   endproperty
   a_flash_stall: assert property (p_flash_stall) else $error("flash stall length wrong");
   property p_start_gate;
      mem_wr |-> go_q;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("write started without key");
   property p_powerup_delay_timer;
      mem_wr && !mem_space |-> up_q >= POWERUP_DELAY_TIMER_CYCLES;
   endproperty
   a_powerup_delay_timer: assert property (p_powerup_delay_timer) else $error("data write during power-up delay");
   property p_rd_start;
      mem_rd |-> rd_q;
   endproperty
   a_rd_start: assert property (p_rd_start) else $error("read strobe without request");
   property p_key_zero;
      pready && !pwrite && paddr[11:2] == nwp_pkg::IDX_KEY |-> prdata == 32'h00000000;
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key port read nonzero");
   property p_ext_wr;
      ext_wr_ok |-> $past(ext_wr_req);
   endproperty
   a_ext_wr: assert property (p_ext_wr) else $error("external write grant unasked");
   property p_ext_rd;
      ext_rd_ok |-> $past(ext_rd_req);
   endproperty
   a_ext_rd: assert property (p_ext_rd) else $error("external read grant unasked");
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   property p_apb_ans;
      psel && !penable |=> s_answer;
   endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("bus answer not one cycle");
endmodule // nwp_checker
bind nwp_top nwp_checker #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) nwp_checker_inst (
   .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .mem_wr,
   .mem_rd, .mem_space, .cpu_stall, .ext_rd_req, .ext_wr_req, .ext_rd_ok, .ext_wr_ok);

// ==== bench/nwp_prog_model.sv ====
// serial programmer and memory array model
`timescale 1ns/10ps
module nwp_prog_model (
   input  wire logic        core_clk,
   input  wire logic        mem_rd,
   input  wire logic [12:0] mem_addr,
   output logic      [13:0] mem_rdata,
   output logic             ext_cfg_wr,
   output logic      [3:0]  ext_cfg_wdata,
   output logic             ext_bulk_erase
);
   initial {mem_rdata, ext_cfg_wr, ext_cfg_wdata, ext_bulk_erase} = '0;
   // inverted off the strobe cycle so a late sample shows
   always @(posedge core_clk)
      mem_rdata <= mem_rd ? {1'b0, mem_addr} ^ 14'h02A5 : ~mem_rdata;
   // only this port touches the configuration word
   task automatic program_cfg(input logic [3:0] v);
      ext_cfg_wr <= 1'b1;
      ext_cfg_wdata <= v;
      @(posedge core_clk);
      ext_cfg_wr <= 1'b0;
      ext_cfg_wdata <= ~v;
      @(posedge core_clk);
   endtask
   // full erase or reset is the only way back to the erased word
   task automatic erase_all;
      ext_bulk_erase <= 1'b1;
      @(posedge core_clk);
      ext_bulk_erase <= 1'b0;
      @(posedge core_clk);
   endtask
endmodule // nwp_prog_model

// ==== bench/tb_top.sv ====
// self-checking bench for the nvm write protection core
`timescale 1ns/10ps
module tb_top;
   localparam int unsigned PW = 40;
   localparam logic [9:0] CTL = nwp_pkg::IDX_CTL;
   localparam logic [9:0] STAT = nwp_pkg::IDX_IRQ_STAT;
   localparam logic [15:0] BK [4] = '{16'hAA55, 16'h5555, 16'h00AA, 16'h55AA};
   localparam logic [7:0] FT [4] = '{8'hE0, 8'hF0, 8'hBC, 8'hB1};
   localparam logic [7:0] XT [6] = '{8'hF3, 8'hFB, 8'h70, 8'hB2, 8'hB8, 8'h90};
   logic        core_clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr, irq;
   logic        mem_wr, mem_rd, mem_space, cpu_stall, prog_area_protected;
   logic        ext_rd_req, ext_wr_req, ext_area_protected, ext_cfg_wr, ext_bulk_erase;
   logic        ext_rd_ok, ext_wr_ok, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [12:0] mem_addr;
   logic [13:0] mem_wdata, mem_rdata, lw;
   logic [3:0]  ext_cfg_wdata;
   logic [7:0]  q;
   int          n_fail, comparisons, n_wr, n_stall, cyc;
   nwp_top #(.POWERUP_DELAY_TIMER_CYCLES(PW), .EE_CYCLES(5)) nwp_top_inst (
      .core_clk, .nrst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .mem_wr, .mem_rd, .mem_space, .mem_addr, .mem_wdata, .mem_rdata,
      .prog_area_protected, .cpu_stall, .ext_rd_req, .ext_wr_req, .ext_area_protected,
      .ext_cfg_wr, .ext_cfg_wdata, .ext_bulk_erase, .ext_rd_ok, .ext_wr_ok);
   nwp_prog_model nwp_prog_model_inst (
      .core_clk, .mem_rd, .mem_addr, .mem_rdata, .ext_cfg_wr, .ext_cfg_wdata, .ext_bulk_erase);
   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (mem_wr === 1'b1) n_wr <= n_wr + 1;
      if (mem_wr === 1'b1) lw <= mem_wdata;
      if (cpu_stall === 1'b1) n_stall <= n_stall + 1;
      if (cyc == 3000) begin
         n_fail++;
         final_report;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk);
      while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic start(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
      apb(1, nwp_pkg::IDX_KEY, k1);
      apb(1, nwp_pkg::IDX_KEY, k2);
      apb(1, CTL, c);
   endtask
   task automatic wait_done;
      do apb(0, CTL, 8'h00);
      while (q[1] !== 1'b0);
   endtask
   task automatic irq_is(input logic v);
      @(posedge core_clk);
      chk(irq, v);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {prog_area_protected, ext_rd_req, ext_wr_req, ext_area_protected} = '0;
      clk_en = 1'b1;
      {n_fail, comparisons, n_wr, n_stall, cyc} = '0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      apb(0, CTL, 8'h00);
      chk(q, 8'h00);
      apb(0, STAT, 8'h00);
      chk(q, 8'h00);
      // inside the power-up delay
      apb(1, CTL, 8'h04);
      start(8'h55, 8'hAA, 8'h06);
      apb(0, CTL, 8'h00);
      chk(q & 8'h0A, 8'h08);
      apb(0, STAT, 8'h00);
      chk(q, 8'h02);
      apb(0, nwp_pkg::IDX_KEY, 8'h00);
      chk(q, 8'h00);
      apb(0, 10'h3FF, 8'h00);
      chk({err, q}, 9'h100);
      apb(1, nwp_pkg::IDX_PEN2, 8'h10);
      apb(0, nwp_pkg::IDX_PEN2, 8'h00);
      chk(q, 8'h10);
      apb(1, nwp_pkg::IDX_IRQ_CLR, 8'hFF);
      apb(1, CTL, 8'h04);
      apb(0, STAT, 8'h00);
      chk(q, 8'h00);
      chk(n_wr[15:0], 16'h0000);
      $display("test power-up done");
      repeat (PW) @(posedge core_clk);
      apb(1, nwp_pkg::IDX_IRQ_EN, 8'h01);
      apb(1, nwp_pkg::IDX_ADDR_LO, 8'h3C);
      apb(1, nwp_pkg::IDX_DATA_LO, 8'h5A);
      apb(1, nwp_pkg::IDX_DATA_HI, 8'hFF);
      start(8'h55, 8'hAA, 8'h06);
      wait_done;
      chk(n_wr[15:0], 16'h0001);
      chk(lw, 14'h3F5A);
      apb(0, STAT, 8'h00);
      chk(q, 8'h01);
      apb(0, nwp_pkg::IDX_PFLAG2, 8'h00);
      chk(q & 8'h10, 8'h10);
      chk(irq, 1'b1);
      apb(1, nwp_pkg::IDX_IRQ_EN, 8'h00);
      irq_is(1'b0);
      apb(1, nwp_pkg::IDX_IRQ_EN, 8'h01);
      irq_is(1'b1);
      apb(1, nwp_pkg::IDX_IRQ_CLR, 8'h01);
      irq_is(1'b0);
      $display("test data write done");
      for (int k = 0; k < 4; k++) begin
         if (k == 3) apb(1, CTL, 8'h00);
         start(BK[k][15:8], BK[k][7:0], 8'h06);
         apb(0, CTL, 8'h00);
         chk(q & 8'h0A, 8'h08);
         apb(1, CTL, 8'h04);
      end
      chk(n_wr[15:0], 16'h0001);
      $display("test key order done");
      for (int k = 0; k < 4; k++) begin
         if (FT[k][3]) nwp_prog_model_inst.erase_all;
         nwp_prog_model_inst.program_cfg(FT[k][7:4]);
         prog_area_protected <= FT[k][2];
         apb(1, CTL, 8'h84);
         start(8'h55, 8'hAA, 8'h86);
         wait_done;
         chk(q[3], !FT[k][0]);
      end
      chk(n_wr[15:0], 16'h0002);
      chk(n_stall[15:0], 16'h0002);
      $display("test flash write done");
      for (int k = 0; k < 6; k++) begin
         nwp_prog_model_inst.erase_all;
         nwp_prog_model_inst.program_cfg(XT[k][7:4]);
         ext_area_protected <= XT[k][3];
         ext_rd_req <= 1'b1;
         ext_wr_req <= 1'b1;
         repeat (2) @(posedge core_clk);
         chk({ext_rd_ok, ext_wr_ok}, XT[k][1:0]);
         ext_rd_req <= 1'b0;
         ext_wr_req <= 1'b0;
      end
      $display("test external port done");
      nwp_prog_model_inst.program_cfg(4'h0);
      for (int k = 0; k < 2; k++) begin
         apb(1, CTL, k ? 8'h81 : 8'h01);
         @(posedge core_clk);
         apb(0, nwp_pkg::IDX_DATA_LO, 8'h00);
         chk(q, 8'h99);
         apb(0, nwp_pkg::IDX_DATA_HI, 8'h00);
         chk(q, 8'h02);
      end
      $display("test processor read done");
      final_report;
   end
endmodule // tb_top
